// ==== rtl/gssm_pkg.sv ====
// Purpose: constants for the gpio status select mux
// Assumes: byte addressed avalon slave, one 32-bit word per register
// Notes:   status codes keep bit 7 set; bits 6:0 are the function code
package gssm_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  GSSM_OFS_PIN_CFG   = 8'h00;
	localparam logic [7:0]  GSSM_OFS_FAIL_MASK = 8'h20;
	localparam logic [7:0]  GSSM_OFS_PIN_STATE = 8'h24;
	localparam logic [7:0]  GSSM_OFS_IRQ_STAT  = 8'h28;
	localparam logic [7:0]  GSSM_OFS_IRQ_MASK  = 8'h2C;
	localparam logic [7:0]  GSSM_OFS_LIVE      = 8'h30;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          GSSM_CFG_CODE_W    = 7;
	localparam int          GSSM_CFG_STAT_BIT  = 7;
	localparam logic [7:0]  GSSM_CFG_RST       = 8'h00;
	localparam logic [15:0] GSSM_FAIL_MASK_RST = 16'hFFFF;
	localparam int          GSSM_NUM_EVT       = 6;
	localparam logic [5:0]  GSSM_IRQ_MASK_RST  = 6'h00;
	localparam int          GSSM_MAX_PINS      = 8;

	// ----------------------------------------------------------------
	// status function codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  GSSM_REF_BASE      = 8'h88;
	localparam logic [7:0]  GSSM_REF_LAST      = 8'hA4;
	localparam logic [2:0]  GSSM_RSUB_FAIL     = 3'h4;
	localparam logic [7:0]  GSSM_DPLL_BASE     = 8'hA8;
	localparam logic [7:0]  GSSM_DPLL_LAST     = 8'hC2;
	localparam logic [3:0]  GSSM_DSUB_NORMAL   = 4'h0;
	localparam logic [3:0]  GSSM_DSUB_HOLD     = 4'h1;
	localparam logic [3:0]  GSSM_DSUB_RSEL_HI  = 4'h2;
	localparam logic [3:0]  GSSM_DSUB_RSEL_LO  = 4'h3;
	localparam logic [3:0]  GSSM_DSUB_LOCK1    = 4'h8;
	localparam logic [3:0]  GSSM_DSUB_LOCK3    = 4'hA;

	typedef enum logic [1:0] {
		GSSM_DPLL_NORMAL,
		GSSM_DPLL_HOLDOVER,
		GSSM_DPLL_FREERUN
	} gssm_dpll_state_type;
endpackage

// ==== rtl/gssm_status_mux.sv ====
// Purpose: routes reference monitor and dpll status onto gpio pins
// Assumes: all status inputs come from logic on mclk
// Notes:   pin outputs are registered, one cycle behind their source
//
// Summary of operation
// - ref0 failure code shows unmasked combined failure
// - mask bit one lets source through
// - ref1 codes select its five indications
// - ref2 codes select its five indications
// - ref3 codes select its five indications
// - dpll0 normal code high while tracking
// - dpll0 holdover code high in holdover
// - two codes give dpll0 reference bits
// - first dpll0 lock indicator passed through
// - second dpll0 lock indicator passed through
// - third dpll0 lock indicator passed through
// - dpll1 normal and holdover like dpll0
// - two codes give dpll1 reference bits
// - three codes give dpll1 lock indicators
// - seven-bit code per pin picks function
// - ref0 codes select its five indications
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module gssm_status_mux
	import gssm_pkg::*;
#(
	parameter int NUM_PINS = 4
) (
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic [3:0]           signal_absent_input,
	input  wire logic [3:0]           single_cycle_check,
	input  wire logic [3:0]           coarse_freq_check,
	input  wire logic [3:0]           guard_soak_timer,
	input  wire gssm_dpll_state_type  dpll0_state,
	input  wire gssm_dpll_state_type  dpll1_state,
	input  wire logic [1:0]           dpll0_ref_sel,
	input  wire logic [1:0]           dpll1_ref_sel,
	input  wire logic [2:0]           dpll0_lock,
	input  wire logic [2:0]           dpll1_lock,
	output logic [NUM_PINS-1:0]       gpio_out,
	output logic [NUM_PINS-1:0]       gpio_oe,
	output logic                      irq
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (NUM_PINS < 1 || NUM_PINS > GSSM_MAX_PINS) begin : g_bad_pins
		$error("NUM_PINS must lie between 1 and 8");
	end

	// ----------------------------------------------------------------
	// status selection
	// ----------------------------------------------------------------
	// ref_bits[r] = {fail, guard, coarse, single, absent}
	// dpll_bits[d] indexed by sub code, holes read zero
	function automatic logic gssm_select(
		input logic [7:0]       sel,
		input logic [3:0][4:0]  ref_bits,
		input logic [1:0][15:0] dpll_bits
	);
		logic [7:0] off;
		logic       res;
		res = 1'b0;
		if (sel >= GSSM_REF_BASE && sel <= GSSM_REF_LAST) begin
			off = sel - GSSM_REF_BASE;
			if (off[2:0] <= GSSM_RSUB_FAIL) begin
				res = ref_bits[off[4:3]][off[2:0]];
			end
		end else if (sel >= GSSM_DPLL_BASE && sel <= GSSM_DPLL_LAST) begin
			off = sel - GSSM_DPLL_BASE;
			res = dpll_bits[off[4]][off[3:0]];
		end
		return res;
	endfunction

	logic [NUM_PINS-1:0][7:0] cfg_reg;
	logic [15:0]              fail_mask_reg;
	logic [3:0]               ref_fail;
	logic [3:0][4:0]          ref_bits;
	logic [1:0][15:0]         dpll_bits;
	logic [NUM_PINS-1:0]      gpio_out_reg;

	always_comb begin
		for (int r = 0; r < 4; r++) begin
			ref_fail[r] = |({guard_soak_timer[r], coarse_freq_check[r],
				single_cycle_check[r], signal_absent_input[r]}
				& fail_mask_reg[4*r +: 4]);
			ref_bits[r] = {ref_fail[r], guard_soak_timer[r], coarse_freq_check[r],
				single_cycle_check[r], signal_absent_input[r]};
		end
	end

	always_comb begin
		dpll_bits = '0;
		dpll_bits[0][GSSM_DSUB_NORMAL]  = (dpll0_state == GSSM_DPLL_NORMAL);
		dpll_bits[0][GSSM_DSUB_HOLD]    = (dpll0_state == GSSM_DPLL_HOLDOVER);
		dpll_bits[0][GSSM_DSUB_RSEL_HI] = dpll0_ref_sel[1];
		dpll_bits[0][GSSM_DSUB_RSEL_LO] = dpll0_ref_sel[0];
		dpll_bits[0][GSSM_DSUB_LOCK3:GSSM_DSUB_LOCK1] = dpll0_lock;
		dpll_bits[1][GSSM_DSUB_NORMAL]  = (dpll1_state == GSSM_DPLL_NORMAL);
		dpll_bits[1][GSSM_DSUB_HOLD]    = (dpll1_state == GSSM_DPLL_HOLDOVER);
		dpll_bits[1][GSSM_DSUB_RSEL_HI] = dpll1_ref_sel[1];
		dpll_bits[1][GSSM_DSUB_RSEL_LO] = dpll1_ref_sel[0];
		dpll_bits[1][GSSM_DSUB_LOCK3:GSSM_DSUB_LOCK1] = dpll1_lock;
	end

	// registering keeps the pin free of decode glitches on code change
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				gpio_out_reg[p] <= 1'b0;
			end else if (cfg_reg[p][GSSM_CFG_STAT_BIT]) begin
				gpio_out_reg[p] <= gssm_select(cfg_reg[p], ref_bits, dpll_bits);
			end else begin
				gpio_out_reg[p] <= 1'b0;
			end
		end
		assign gpio_oe[p] = cfg_reg[p][GSSM_CFG_STAT_BIT];
	end

	assign gpio_out = gpio_out_reg;

	// ----------------------------------------------------------------
	// avalon slave
	// ----------------------------------------------------------------
	// fixed one wait state: data sampled when waitrequest drops
	logic        ack_reg;
	logic        req;
	logic        wr_fire;
	logic [31:0] readdata_reg;
	logic [31:0] rd_next;
	logic [5:0]  irq_stat_reg;
	logic [5:0]  irq_mask_reg;

	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_reg;
	assign wr_fire         = avs_write & ack_reg;
	assign avs_readdata    = readdata_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	always_comb begin
		rd_next = '0;
		if (avs_address < GSSM_OFS_PIN_CFG + 8'(4 * NUM_PINS)
			&& avs_address[1:0] == 2'h0) begin
			rd_next[7:0] = cfg_reg[avs_address[4:2]];
		end else begin
			unique case (avs_address)
				GSSM_OFS_FAIL_MASK: rd_next[15:0] = fail_mask_reg;
				GSSM_OFS_PIN_STATE: rd_next[NUM_PINS-1:0] = gpio_out_reg;
				GSSM_OFS_IRQ_STAT:  rd_next[5:0] = irq_stat_reg;
				GSSM_OFS_IRQ_MASK:  rd_next[5:0] = irq_mask_reg;
				GSSM_OFS_LIVE:      rd_next[5:0] = {dpll1_state == GSSM_DPLL_HOLDOVER,
					dpll0_state == GSSM_DPLL_HOLDOVER, ref_fail};
				default:            rd_next = '0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			readdata_reg <= '0;
		end else if (avs_read & ~ack_reg) begin
			readdata_reg <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_cfg
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				cfg_reg[p] <= GSSM_CFG_RST;
			end else if (wr_fire && avs_address == GSSM_OFS_PIN_CFG + 8'(4 * p)) begin
				cfg_reg[p] <= avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fail_mask_reg <= GSSM_FAIL_MASK_RST;
		end else if (wr_fire && avs_address == GSSM_OFS_FAIL_MASK) begin
			fail_mask_reg <= avs_writedata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// events: rise of each ref failure, entry into holdover per dpll
	logic [5:0] evt_lvl;
	logic [5:0] evt_prev_reg;
	logic [5:0] evt_pulse;

	assign evt_lvl   = {dpll1_state == GSSM_DPLL_HOLDOVER,
		dpll0_state == GSSM_DPLL_HOLDOVER, ref_fail};
	assign evt_pulse = evt_lvl & ~evt_prev_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			evt_prev_reg <= '0;
		end else begin
			evt_prev_reg <= evt_lvl;
		end
	end

	// a new event beats a clear landing in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_reg <= '0;
		end else if (wr_fire && avs_address == GSSM_OFS_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg & ~avs_writedata[5:0]) | evt_pulse;
		end else begin
			irq_stat_reg <= irq_stat_reg | evt_pulse;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_reg <= GSSM_IRQ_MASK_RST;
		end else if (wr_fire && avs_address == GSSM_OFS_IRQ_MASK) begin
			irq_mask_reg <= avs_writedata[5:0];
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------------------------------
	// assertions on ref0 failure, pin 0 selection and interrupt status
	// ----------------------------------------------------------------
	default clocking a_clk @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_fail_combine: assert property (
		(signal_absent_input[0] && fail_mask_reg[0]) |-> ref_fail[0]
	) else $error("ref0 failure missing for unmasked absent signal");

	a_mask_blocks: assert property (
		(!fail_mask_reg[0] && signal_absent_input[0] && !single_cycle_check[0]
			&& !coarse_freq_check[0] && !guard_soak_timer[0]) |-> !ref_fail[0]
	) else $error("masked sources still raise ref0 failure");

	a_ref1_fail: assert property (
		(cfg_reg[0] == 8'h94) ##1 (cfg_reg[0] == 8'h94)
		|-> gpio_out[0] == $past(ref_fail[1])
	) else $error("pin does not follow ref1 failure");

	a_ref2_single: assert property (
		(cfg_reg[0] == 8'h99) ##1 (cfg_reg[0] == 8'h99)
		|-> gpio_out[0] == $past(single_cycle_check[2])
	) else $error("pin does not follow ref2 single cycle check");

	a_ref3_guard: assert property (
		(cfg_reg[0] == 8'hA3) |=> gpio_out[0] == $past(guard_soak_timer[3])
	) else $error("pin does not follow ref3 guard soak");

	a_dpll0_normal: assert property (
		(cfg_reg[0] == 8'hA8 && dpll0_state == GSSM_DPLL_FREERUN) |=> !gpio_out[0]
	) else $error("normal indication high during freerun");

	a_dpll0_hold: assert property (
		(cfg_reg[0] == 8'hA9 && dpll0_state == GSSM_DPLL_HOLDOVER) |=> gpio_out[0]
	) else $error("holdover indication low in holdover");

	a_dpll0_rsel: assert property (
		(cfg_reg[0] == 8'hAA) |=> gpio_out[0] == $past(dpll0_ref_sel[1])
	) else $error("pin does not show dpll0 reference bit1");

	a_dpll1_lock3: assert property (
		(cfg_reg[0] == 8'hC2) |=> gpio_out[0] == $past(dpll1_lock[2])
	) else $error("pin does not show dpll1 third lock indicator");

	a_undef_low: assert property (
		(cfg_reg[0] == 8'hA5 || cfg_reg[0] == 8'hB3) |=> !gpio_out[0]
	) else $error("undefined code does not drive pin low");

	a_ref0_absent: assert property (
		(cfg_reg[0] == 8'h88) |=> gpio_out[0] == $past(signal_absent_input[0])
	) else $error("pin does not follow ref0 absent signal");

	a_ref0_fail_pin: assert property (
		(cfg_reg[0] == 8'h8C && signal_absent_input[0] && fail_mask_reg[0]) |=> gpio_out[0]
	) else $error("ref0 failure code low for unmasked absent signal");

	a_ref1_absent: assert property (
		(cfg_reg[0] == 8'h90) |=> gpio_out[0] == $past(signal_absent_input[1])
	) else $error("pin does not follow ref1 absent signal");

	a_ref2_fail: assert property (
		(cfg_reg[0] == 8'h9C && coarse_freq_check[2] && fail_mask_reg[10]) |=> gpio_out[0]
	) else $error("ref2 failure code low for unmasked coarse check");

	a_ref3_fail: assert property (
		(cfg_reg[0] == 8'hA4 && guard_soak_timer[3] && fail_mask_reg[15]) |=> gpio_out[0]
	) else $error("ref3 failure code low for unmasked guard soak");

	a_dpll0_rsel_lo: assert property (
		(cfg_reg[0] == 8'hAB) |=> gpio_out[0] == $past(dpll0_ref_sel[0])
	) else $error("pin does not show dpll0 reference bit0");

	a_dpll0_lock1: assert property (
		(cfg_reg[0] == 8'hB0) |=> gpio_out[0] == $past(dpll0_lock[0])
	) else $error("pin does not show dpll0 first lock indicator");

	a_dpll0_lock2: assert property (
		(cfg_reg[0] == 8'hB1) |=> gpio_out[0] == $past(dpll0_lock[1])
	) else $error("pin does not show dpll0 second lock indicator");

	a_dpll0_lock3: assert property (
		(cfg_reg[0] == 8'hB2) |=> gpio_out[0] == $past(dpll0_lock[2])
	) else $error("pin does not show dpll0 third lock indicator");

	a_dpll1_normal: assert property (
		(cfg_reg[0] == 8'hB8) |=> gpio_out[0] == ($past(dpll1_state) == GSSM_DPLL_NORMAL)
	) else $error("pin does not show dpll1 normal state");

	a_dpll1_rsel: assert property (
		(cfg_reg[0] == 8'hBA) |=> gpio_out[0] == $past(dpll1_ref_sel[1])
	) else $error("pin does not show dpll1 reference bit1");

	a_cfg_off: assert property (
		(!cfg_reg[0][GSSM_CFG_STAT_BIT]) |=> !gpio_out[0]
	) else $error("pin driven high outside status mode");

	a_irq_setwins: assert property (
		evt_pulse[0] |=> irq_stat_reg[0]
	) else $error("event lost in status register");

endmodule

`default_nettype wire

// ==== tb/gssm_pin_sampler.sv ====
// Purpose: external controller model that samples the status pins
// Assumes: pins carry a pull-down, so an undriven pin reads low
// Notes:   one register stage, like a controller sampling on mclk
`timescale 1ns/1ps
`default_nettype none

module gssm_pin_sampler #(
	parameter int N = 4
) (
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	output logic      [N-1:0] seen_reg
);
	// pin not driven: pull-down wins, never the stale level
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) seen_reg <= '0;
		else seen_reg <= pin_out & pin_oe;
	end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the gpio status select mux
// Assumes: one wait state per bus access, pins one cycle behind source
// Notes:   pin 0 carries each selection, pins 1 to 3 only code 8C; pin sampler adds one stage
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import gssm_pkg::*;
;
	logic                mclk = 1'b0;
	logic                arst_n = 1'b0;
	logic [7:0]          avs_address = 8'h00;
	logic                avs_read = 1'b0;
	logic                avs_write = 1'b0;
	logic [31:0]         avs_writedata = 32'h0;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic [3:0]          srcv [4];
	gssm_dpll_state_type dst [2];
	logic [1:0]          rs [2];
	logic [2:0]          lk [2];
	logic [3:0]          gpio_out;
	logic [3:0]          gpio_oe;
	logic [3:0]          seen_reg;
	logic                irq;
	int                  err_total = 0;
	int                  checks_done = 0;

	always #5 mclk = ~mclk;

	gssm_status_mux #(.NUM_PINS(4)) i_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.signal_absent_input(srcv[0]), .single_cycle_check(srcv[1]), .coarse_freq_check(srcv[2]),
		.guard_soak_timer(srcv[3]), .dpll0_state(dst[0]), .dpll1_state(dst[1]),
		.dpll0_ref_sel(rs[0]), .dpll1_ref_sel(rs[1]), .dpll0_lock(lk[0]), .dpll1_lock(lk[1]),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq));

	gssm_pin_sampler #(.N(4)) i_ctl (.mclk(mclk), .arst_n(arst_n), .pin_out(gpio_out),
		.pin_oe(gpio_oe), .seen_reg(seen_reg));

	task automatic summarize;
		if (err_total == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// bus master: hold request until waitrequest is seen low
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			$display("CHECK FAILED t=%0t bus request not answered", $time);
			err_total++;
			summarize();
		end
	endtask

	// pin 0 to code, then two stages of latency before sampling
	task automatic pin(input logic [7:0] code, input logic e);
		logic [31:0] q;
		bus(1'b1, 8'h00, {24'h0, code}, q);
		repeat (3) @(posedge mclk);
		chk({31'h0, seen_reg[0]}, {31'h0, e});
		bus(1'b0, GSSM_OFS_PIN_STATE, 32'h0, q);
		chk({31'h0, q[0]}, {31'h0, e});
	endtask

	task automatic pin2(input logic [7:0] code, input logic e0, input logic e1);
		pin(code, e0);
		pin(code + 8'h01, e1);
	endtask

	task automatic t_reset;
		logic [31:0] q;
		chk({28'h0, gpio_oe}, 32'h0);
		bus(1'b0, 8'h20, 32'h0, q);
		chk(q, 32'h0000FFFF);
		bus(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, 8'h3C, 32'h0, q);
		chk(q, 32'h0);
	endtask

	task automatic t_ref;
		logic [31:0] q;
		for (int r = 0; r < 4; r++) begin
			for (int s = 0; s < 4; s++) begin
				srcv[s][r] <= 1'b1;
				pin(8'(8'h88 + 8 * r + s), 1'b1);
				pin(8'(8'h8C + 8 * r), 1'b1);
				pin(8'(8'h88 + 8 * ((r + 1) % 4) + s), 1'b0);
				bus(1'b1, 8'h20, 32'hFFFF ^ (32'h1 << (4 * r + s)), q);
				pin(8'(8'h8C + 8 * r), 1'b0);
				bus(1'b1, 8'h20, 32'h0000FFFF, q);
				srcv[s][r] <= 1'b0;
			end
		end
	endtask

	task automatic t_dpll;
		logic [7:0] b;
		for (int d = 0; d < 2; d++) begin
			b = 8'(8'hA8 + 16 * d);
			dst[d] <= GSSM_DPLL_HOLDOVER;
			pin2(b, 1'b0, 1'b1);
			dst[d] <= GSSM_DPLL_FREERUN;
			pin2(b, 1'b0, 1'b0);
			dst[d] <= GSSM_DPLL_NORMAL;
			pin2(b, 1'b1, 1'b0);
			rs[d] <= 2'b10;
			pin2(b + 8'h02, 1'b1, 1'b0);
			rs[d] <= 2'b01;
			pin2(b + 8'h02, 1'b0, 1'b1);
			lk[d] <= 3'b001;
			pin2(b + 8'h08, 1'b1, 1'b0);
			lk[d] <= 3'b010;
			pin2(b + 8'h09, 1'b1, 1'b0);
			lk[d] <= 3'b100;
			pin2(b + 8'h09, 1'b0, 1'b1);
		end
	endtask

	// every reference monitor source high, so any leak onto the pin shows up
	task automatic t_undef;
		logic [31:0] q;
		for (int s = 0; s < 4; s++) srcv[s] <= 4'hF;
		pin2(8'h8D, 1'b0, 1'b0);
		pin2(8'hAC, 1'b0, 1'b0);
		pin2(8'hB3, 1'b0, 1'b0);
		pin(8'hA5, 1'b0);
		pin(8'h80, 1'b0);
		pin(8'h0C, 1'b0);
		for (int p = 1; p < 4; p++) bus(1'b1, 8'(4 * p), 32'h8C, q);
		repeat (3) @(posedge mclk);
		chk({28'h0, seen_reg}, 32'hE);
		chk({28'h0, gpio_oe}, 32'hE);
	endtask

	task automatic t_irq;
		logic [31:0] q;
		bus(1'b1, 8'h28, 32'h3F, q);
		bus(1'b1, 8'h2C, 32'h10, q);
		chk({31'h0, irq}, 32'h0);
		dst[0] <= GSSM_DPLL_HOLDOVER;
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, 8'h28, 32'h0, q);
		chk(q, 32'h10);
		bus(1'b1, 8'h28, 32'h10, q);
		@(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h2C, 32'h0, q);
		dst[0] <= GSSM_DPLL_NORMAL;
		repeat (2) @(posedge mclk);
		dst[0] <= GSSM_DPLL_HOLDOVER;
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 8'h28, 32'h0, q);
		chk(q, 32'h10);
		bus(1'b0, GSSM_OFS_LIVE, 32'h0, q);
		chk(q, 32'h1F);
	endtask

	initial begin
		for (int s = 0; s < 4; s++) srcv[s] = 4'h0;
		for (int d = 0; d < 2; d++) begin
			dst[d] = GSSM_DPLL_NORMAL;
			rs[d] = 2'b00;
			lk[d] = 3'b000;
		end
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_ref();
		t_dpll();
		t_undef();
		t_irq();
		summarize();
	end
endmodule

`default_nettype wire
